// File: bench/tb_clock_and_port_reset_config.sv
// Self-checking testbench of the clock and port reset configuration block.
`timescale 1ns/1ps
module tb_clock_and_port_reset_config;
   import ccprc_pkg::*;
   localparam logic [7:0] CAL = 8'h5a;  // Calibration byte handed to the design.
   logic        clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic        pclk = 0, lse = 0, hsi = 0, req = 0, bset = 0, bclr = 0;
   logic [7:0]  awa = 0, ara = 0, cal;
   logic [31:0] wd = 0, rdat;
   logic [3:0]  ws = 0, div;
   logic [1:0]  br, rr;
   logic [4:0]  prst, trim;
   logic        awr, wr_rdy, bv, arr, rv, uk, ik, asel, on;
   int          err_count = 0, n_checks = 0;
   logic [34:0] q[$];  // Expected responses, oldest first.
   always #5 clk = ~clk;
   always #7 pclk = ~pclk;
   always #11 hsi = ~hsi;
   always #61 lse = ~lse;
   ccprc_top #(.CAL_VALUE(CAL)) dut (.i_sys_clk(clk), .i_resetn(rstn), .i_s_axi_awaddr(awa),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
      .i_pclk(pclk), .i_system_clock(clk), .i_low_speed_external_clock(lse),
      .i_high_speed_internal_clock(hsi), .i_adc_osc_request(req), .i_adc_osc_block_set(bset),
      .i_adc_osc_block_clr(bclr), .o_port_reset(prst), .o_pll_input_div(div),
      .o_uart_kernel_clock(uk), .o_i2c_kernel_clock(ik), .o_adc_clock_select(asel),
      .o_adc_osc_on(on), .o_adc_osc_trim(trim), .o_adc_osc_calibration(cal));
   // Counts one comparison and reports a miss at once.
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Bus write: both channels offered together, response awaited with bready high.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      int n;
      @(posedge clk);
      q.push_back({1'b0, r, 32'h0});
      awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= 1;
      do @(posedge clk); while (awr !== 1'b1);
      awv <= 0; wv <= 0; n = 0;
      do begin @(posedge clk); n++; end while (bv !== 1'b1);
      bry <= 0;
      chk(n == 1, "write answer late");
   endtask
   // Bus read: the expected word and response are queued for the monitor.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n;
      @(posedge clk);
      q.push_back({1'b1, r, e});
      ara <= a; arv <= 1; rry <= 1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 0; n = 0;
      do begin @(posedge clk); n++; end while (rv !== 1'b1);
      rry <= 0;
      chk(n == 1, "read answer late");
   endtask
   // Monitor: each completed response is matched against the oldest note.
   always @(posedge clk) begin
      logic [34:0] e;
      if (bv === 1'b1 && bry === 1'b1) begin
         e = q.pop_front();
         chk(e[34] === 1'b0 && br === e[33:32], "write response mismatch");
      end
      if (rv === 1'b1 && rry === 1'b1) begin
         e = q.pop_front();
         chk(e[34] === 1'b1 && {rr, rdat} === e[33:0], "read data mismatch");
      end
   end
   // Watchdog cuts a hang short.
   initial begin
      #100000;
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop;
   end
   // Main sequence of tests.
   initial begin
      int s;
      logic [31:0] v;
      logic [4:0]  t;
      s = $urandom(32'hdd87);
      repeat (2) @(posedge clk);
      rstn <= 1;
      rd(OFF_GPIO_PORT_RESET, RST_ZERO, RESP_OKAY);
      rd(OFF_PLL_INPUT_DIVIDER, RST_ZERO, RESP_OKAY);
      rd(OFF_PERIPH_CLOCK_SEL, RST_ZERO, RESP_OKAY);
      rd(OFF_ADC_OSC_CONTROL, {16'h0, CAL, RST_OSC_TRIM, 3'h0}, RESP_OKAY);
      chk(trim === RST_OSC_TRIM && cal === CAL && prst === 5'h0, "reset outputs");
      $display("test reset done");
      wr(OFF_GPIO_PORT_RESET, 32'hffff_ffff, 4'hf, RESP_OKAY);
      rd(OFF_GPIO_PORT_RESET, MASK_GPIO_PORT_RESET, RESP_OKAY);
      chk(prst === 5'h1f, "ports not held");
      v = $urandom;
      wr(OFF_GPIO_PORT_RESET, v, 4'h4, RESP_OKAY);
      rd(OFF_GPIO_PORT_RESET, v & MASK_GPIO_PORT_RESET, RESP_OKAY);
      wr(OFF_GPIO_PORT_RESET, 32'h0, 4'hf, RESP_OKAY);
      chk(prst === 5'h0, "ports not released");
      $display("test port reset done");
      for (int k = 0; k < 16; k++) begin
         v = $urandom;
         v[3:0] = k[3:0];
         wr(OFF_PLL_INPUT_DIVIDER, v, 4'hf, RESP_OKAY);
         rd(OFF_PLL_INPUT_DIVIDER, {28'h0, v[3:0]}, RESP_OKAY);
         chk(div === k[3:0], "divider code");
      end
      // Each selector setting is left to settle for 100 cycles, then each kernel clock is compared once with its source, 2.5 ns after a system clock edge.
      for (int k = 0; k < 8; k++) begin
         v = $urandom & 32'hffff_feff;
         v[1:0] = k[1:0];
         v[4] = k[2];
         wr(OFF_PERIPH_CLOCK_SEL, v, 4'hf, RESP_OKAY);
         rd(OFF_PERIPH_CLOCK_SEL, v & MASK_PERIPH_SEL, RESP_OKAY);
         chk(asel === 1'b0, "adc select moved");
         repeat (100) @(posedge clk);
         #2.5;
         chk(uk === (k[1] ? (k[0] ? hsi : lse) : (k[0] ? clk : pclk)), "uart clock source");
         chk(ik === (k[2] ? clk : hsi), "i2c clock source");
      end
      $display("test divider and selectors done");
      t = $urandom;
      wr(OFF_ADC_OSC_CONTROL, {16'hffff, 8'hff, t, 3'b011}, 4'hf, RESP_OKAY);
      chk(on === 1'b1 && trim === t, "oscillator not started");
      rd(OFF_ADC_OSC_CONTROL, {16'h0, CAL, t, 3'b001}, RESP_OKAY);
      repeat (30) @(posedge clk);
      rd(OFF_ADC_OSC_CONTROL, {16'h0, CAL, t, 3'b011}, RESP_OKAY);
      wr(OFF_ADC_OSC_CONTROL, {24'h0, t, 3'b000}, 4'h3, RESP_OKAY);
      repeat (30) @(posedge clk);
      rd(OFF_ADC_OSC_CONTROL, {16'h0, CAL, t, 3'b000}, RESP_OKAY);
      req <= 1;
      @(posedge clk);
      chk(on === 1'b1, "request ignored");
      wr(OFF_ADC_OSC_CONTROL, {24'h0, t, 3'b100}, 4'h1, RESP_OKAY);
      chk(on === 1'b0, "request not blocked");
      req <= 0;
      bclr <= 1;
      @(posedge clk);
      bclr <= 0;
      rd(OFF_ADC_OSC_CONTROL, {16'h0, CAL, t, 3'b000}, RESP_OKAY);
      // Set and clear together: the hardware set wins.
      bset <= 1;
      bclr <= 1;
      @(posedge clk);
      bset <= 0;
      bclr <= 0;
      rd(OFF_ADC_OSC_CONTROL, {16'h0, CAL, t, 3'b100}, RESP_OKAY);
      $display("test oscillator done");
      rd(8'h38, 32'h0, RESP_SLVERR);
      wr(8'h3c, $urandom, 4'hf, RESP_SLVERR);
      $display("test unmapped done");
      report_and_stop;
   end
endmodule

// File: hw/ccprc_glitch_free_mux.sv
// Glitch-free two-input clock multiplexer used by the kernel clock selectors.
`timescale 1ns/1ps
module ccprc_glitch_free_mux (
   input  wire logic i_resetn,   // Asynchronous reset, active low.
   input  wire logic i_clk0,     // Source taken when select is 0.
   input  wire logic i_clk1,     // Source taken when select is 1.
   input  wire logic i_sel,      // Source select, from a register.
   output logic      o_clk       // Switched clock.
);

   logic en0_a_r;  // Enable of source 0, first stage.
   logic en0_r;    // Enable of source 0, on falling edge.
   logic en1_a_r;  // Enable of source 1, first stage.
   logic en1_r;    // Enable of source 1, on falling edge.

   // Source 0 opens only after source 1 has closed, so no runt pulse appears.
   always_ff @(posedge i_clk0 or negedge i_resetn) begin
      if (!i_resetn) begin
         en0_a_r <= 1'b0;
      end else begin
         en0_a_r <= ~i_sel & ~en1_r;
      end
   end

   // The enable changes only while source 0 is low.
   always_ff @(negedge i_clk0 or negedge i_resetn) begin
      if (!i_resetn) begin
         en0_r <= 1'b0;
      end else begin
         en0_r <= en0_a_r;
      end
   end

   // Source 1 side mirrors source 0.
   always_ff @(posedge i_clk1 or negedge i_resetn) begin
      if (!i_resetn) begin
         en1_a_r <= 1'b0;
      end else begin
         en1_a_r <= i_sel & ~en0_r;
      end
   end

   // The enable changes only while source 1 is low.
   always_ff @(negedge i_clk1 or negedge i_resetn) begin
      if (!i_resetn) begin
         en1_r <= 1'b0;
      end else begin
         en1_r <= en1_a_r;
      end
   end

   // Gated sources are combined; at most one enable is high.
   assign o_clk = (i_clk0 & en0_r) | (i_clk1 & en1_r);

endmodule

// File: hw/ccprc_pkg.sv
// Package of offsets, field positions, reset values and encodings for the clock and port reset block.
package ccprc_pkg;

   // ****************************************************************
   // Register offsets (byte addresses).
   // ****************************************************************
   localparam logic [7:0] OFF_GPIO_PORT_RESET    = 8'h28;
   localparam logic [7:0] OFF_PLL_INPUT_DIVIDER  = 8'h2c;
   localparam logic [7:0] OFF_PERIPH_CLOCK_SEL   = 8'h30;
   localparam logic [7:0] OFF_ADC_OSC_CONTROL    = 8'h34;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int POS_PORT_A_RESET   = 17;
   localparam int POS_PORT_B_RESET   = 18;
   localparam int POS_PORT_C_RESET   = 19;
   localparam int POS_PORT_D_RESET   = 20;
   localparam int POS_PORT_F_RESET   = 22;
   localparam int POS_PLL_DIV_LSB    = 0;
   localparam int POS_UART_SEL_LSB   = 0;
   localparam int POS_I2C_SEL        = 4;
   localparam int POS_ADC_SEL        = 8;
   localparam int POS_OSC_ENABLE     = 0;
   localparam int POS_OSC_READY      = 1;
   localparam int POS_OSC_REQ_BLOCK  = 2;
   localparam int POS_OSC_TRIM_LSB   = 3;
   localparam int POS_OSC_CAL_LSB    = 8;

   // ****************************************************************
   // Writable masks and reset values.
   // ****************************************************************
   localparam logic [31:0] MASK_GPIO_PORT_RESET = 32'h005e_0000;
   localparam logic [31:0] MASK_PLL_DIV         = 32'h0000_000f;
   localparam logic [31:0] MASK_PERIPH_SEL      = 32'h0000_0113;
   localparam logic [31:0] RST_ZERO             = 32'h0000_0000;
   localparam logic [4:0]  RST_OSC_TRIM         = 5'h10;
   localparam logic [7:0]  CAL_DEFAULT          = 8'h80;

   // ****************************************************************
   // Clock source encodings.
   // ****************************************************************
   localparam logic [1:0] UART_SRC_PCLK   = 2'h0;
   localparam logic [1:0] UART_SRC_SYSTEM_CLOCK = 2'h1;
   localparam logic [1:0] UART_SRC_LSE    = 2'h2;
   localparam logic [1:0] UART_SRC_HSI    = 2'h3;

   // ****************************************************************
   // AXI4-Lite responses.
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Oscillator ready sequencer states.
   typedef enum logic [2:0] {
      OSC_OFF   = 3'b001,
      OSC_START = 3'b010,
      OSC_ON    = 3'b100
   } ccprc_osc_t;

   // Ready settle time in cycles of the system clock; a stop takes effect without settling.
   localparam int OSC_SETTLE_CYCLES = 16;

   // Merge a byte-strobed write into an old value under a writable mask.
   function automatic logic [31:0] ccprc_merge(input logic [31:0] old_v, input logic [31:0] wd,
                                               input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] lane;
      lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old_v & ~(lane & wmask)) | (wd & lane & wmask);
   endfunction

endpackage

// File: hw/ccprc_top.sv
// Clock and port reset configuration registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
module ccprc_top #(
   parameter logic [7:0] CAL_VALUE = ccprc_pkg::CAL_DEFAULT  // Factory calibration byte.
) (
   input  wire logic        i_sys_clk,            // System clock, 100 MHz.
   input  wire logic        i_resetn,             // Asynchronous reset, active low.
   input  wire logic [7:0]  i_s_axi_awaddr,       // Write address.
   input  wire logic        i_s_axi_awvalid,      // Write address valid.
   output logic             o_s_axi_awready,      // Write address ready.
   input  wire logic [31:0] i_s_axi_wdata,        // Write data.
   input  wire logic [3:0]  i_s_axi_wstrb,        // Write byte strobes.
   input  wire logic        i_s_axi_wvalid,       // Write data valid.
   output logic             o_s_axi_wready,       // Write data ready.
   output logic [1:0]       o_s_axi_bresp,        // Write response.
   output logic             o_s_axi_bvalid,       // Write response valid.
   input  wire logic        i_s_axi_bready,       // Write response ready.
   input  wire logic [7:0]  i_s_axi_araddr,       // Read address.
   input  wire logic        i_s_axi_arvalid,      // Read address valid.
   output logic             o_s_axi_arready,      // Read address ready.
   output logic [31:0]      o_s_axi_rdata,        // Read data.
   output logic [1:0]       o_s_axi_rresp,        // Read response.
   output logic             o_s_axi_rvalid,       // Read data valid.
   input  wire logic        i_s_axi_rready,       // Read data ready.
   input  wire logic        i_pclk,               // Peripheral bus clock source.
   input  wire logic        i_system_clock,       // System clock source for kernels.
   input  wire logic        i_low_speed_external_clock,   // Low-speed external source.
   input  wire logic        i_high_speed_internal_clock,  // High-speed internal source.
   input  wire logic        i_adc_osc_request,    // ADC interface asks for the 14 MHz oscillator.
   input  wire logic        i_adc_osc_block_set,  // Hardware sets the request block bit.
   input  wire logic        i_adc_osc_block_clr,  // Hardware clears the request block bit.
   output logic [4:0]       o_port_reset,         // Port resets A,B,C,D,F, active high.
   output logic [3:0]       o_pll_input_div,      // PLL input divider code.
   output logic             o_uart_kernel_clock,  // Selected UART kernel clock.
   output logic             o_i2c_kernel_clock,   // Selected I2C kernel clock.
   output logic             o_adc_clock_select,   // ADC clock source select bit.
   output logic             o_adc_osc_on,         // Run command to the 14 MHz oscillator.
   output logic [4:0]       o_adc_osc_trim,       // Trim to the 14 MHz oscillator.
   output logic [7:0]       o_adc_osc_calibration // Calibration to the 14 MHz oscillator.
);
   import ccprc_pkg::*;
   // Every assertion of this module runs on the system clock and rests during reset.
   default clocking cb_sys @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [31:0] port_rst_r;     // Port reset register.
   logic [31:0] pll_div_r;      // PLL input divider register.
   logic [31:0] clk_sel_r;      // Peripheral clock select register.
   logic        osc_en_r;       // Oscillator enable.
   logic        osc_blk_r;      // ADC request block bit.
   logic [4:0]  osc_trim_r;     // Oscillator trim.
   logic [7:0]  osc_cal_r;      // Calibration byte.
   logic        cal_loaded_r;   // Calibration has been taken after reset.
   ccprc_osc_t  osc_state_r;    // Ready sequencer state.
   ccprc_osc_t  osc_state_nxt;  // Next sequencer state.
   logic [4:0]  osc_cnt_r;      // Settle counter.
   logic        bvalid_r;       // Write response pending.
   logic [1:0]  bresp_r;        // Stored write response.
   logic        rvalid_r;       // Read data pending.
   logic [1:0]  rresp_r;        // Stored read response.
   logic [31:0] rdata_r;        // Stored read data.

   // ****************************************************************
   // Bus decode.
   // ****************************************************************
   // A write is taken only when address and data are both present.
   wire        wr_go   = i_s_axi_awvalid & i_s_axi_wvalid & ~bvalid_r;
   wire        rd_go   = i_s_axi_arvalid & ~rvalid_r;
   wire [7:0]  wa      = {i_s_axi_awaddr[7:2], 2'b00};
   wire [7:0]  ra      = {i_s_axi_araddr[7:2], 2'b00};
   wire        wr_prt  = wr_go & (wa == OFF_GPIO_PORT_RESET);
   wire        wr_pll  = wr_go & (wa == OFF_PLL_INPUT_DIVIDER);
   wire        wr_sel  = wr_go & (wa == OFF_PERIPH_CLOCK_SEL);
   wire        wr_osc  = wr_go & (wa == OFF_ADC_OSC_CONTROL);
   wire        wr_hit  = wr_prt | wr_pll | wr_sel | wr_osc;
   wire [31:0] osc_img = {16'h0000, osc_cal_r, osc_trim_r, osc_blk_r,
                          (osc_state_r == OSC_ON), osc_en_r};
   wire [31:0] osc_new = ccprc_merge(osc_img, i_s_axi_wdata, i_s_axi_wstrb, 32'h0000_00fd);
   wire        rd_hit  = (ra == OFF_GPIO_PORT_RESET) | (ra == OFF_PLL_INPUT_DIVIDER) |
                         (ra == OFF_PERIPH_CLOCK_SEL) | (ra == OFF_ADC_OSC_CONTROL);
   wire [31:0] rd_mux  = (ra == OFF_GPIO_PORT_RESET)   ? port_rst_r :
                         (ra == OFF_PLL_INPUT_DIVIDER) ? pll_div_r  :
                         (ra == OFF_PERIPH_CLOCK_SEL)  ? clk_sel_r  :
                         (ra == OFF_ADC_OSC_CONTROL)   ? osc_img    : RST_ZERO;

   // Ready outputs are combinational, valids are registered; address and data are taken together.
   assign o_s_axi_awready = wr_go;
   assign o_s_axi_wready  = wr_go;
   assign o_s_axi_arready = rd_go;
   assign o_s_axi_bvalid  = bvalid_r;
   assign o_s_axi_bresp   = bresp_r;
   assign o_s_axi_rvalid  = rvalid_r;
   assign o_s_axi_rresp   = rresp_r;
   assign o_s_axi_rdata   = rdata_r;

   // ****************************************************************
   // Bus response channel.
   // ****************************************************************
   // single-cycle answers. Every access completes one cycle after it is taken.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= RST_ZERO;
      end else begin
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= rd_mux;
         end else if (i_s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Configuration registers.
   // ****************************************************************
   // zero reset. Masks keep reserved bits at zero.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         port_rst_r <= RST_ZERO;
         pll_div_r  <= RST_ZERO;
         clk_sel_r  <= RST_ZERO;
      end else begin
         if (wr_prt) begin
            port_rst_r <= ccprc_merge(port_rst_r, i_s_axi_wdata, i_s_axi_wstrb, MASK_GPIO_PORT_RESET);
         end
         if (wr_pll) begin
            pll_div_r <= ccprc_merge(pll_div_r, i_s_axi_wdata, i_s_axi_wstrb, MASK_PLL_DIV);
         end
         if (wr_sel) begin
            clk_sel_r <= ccprc_merge(clk_sel_r, i_s_axi_wdata, i_s_axi_wstrb, MASK_PERIPH_SEL);
         end
      end
   end

   // ****************************************************************
   // Oscillator control register.
   // ****************************************************************
   // enable, block, trim. Hardware set of the block bit wins over a clear.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_en_r   <= 1'b0;
         osc_blk_r  <= 1'b0;
         osc_trim_r <= RST_OSC_TRIM;
      end else begin
         if (wr_osc) begin
            osc_en_r   <= osc_new[POS_OSC_ENABLE];
            osc_trim_r <= osc_new[POS_OSC_TRIM_LSB +: 5];
         end
         if (i_adc_osc_block_set) begin
            osc_blk_r <= 1'b1;
         end else if (i_adc_osc_block_clr) begin
            osc_blk_r <= 1'b0;
         end else if (wr_osc) begin
            osc_blk_r <= osc_new[POS_OSC_REQ_BLOCK];
         end
      end
   end

   // factory load. The calibration is caught once, after reset release.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_cal_r    <= 8'h00;
         cal_loaded_r <= 1'b0;
      end else if (!cal_loaded_r) begin
         osc_cal_r    <= CAL_VALUE;
         cal_loaded_r <= 1'b1;
      end
   end

   // ****************************************************************
   // Oscillator ready sequencer.
   // ****************************************************************
   // The oscillator runs for software, or for an ADC request not blocked.
   assign o_adc_osc_on = osc_en_r | (i_adc_osc_request & ~osc_blk_r);

   // ready tracking. Ready rises after settling and falls once the oscillator stops.
   always_comb begin
      osc_state_nxt = osc_state_r;
      unique case (osc_state_r)
         OSC_OFF:   osc_state_nxt = o_adc_osc_on ? OSC_START : OSC_OFF;
         // Settling is counted out; a stop on the way returns to off.
         OSC_START: osc_state_nxt = !o_adc_osc_on ? OSC_OFF :
                                    (osc_cnt_r == 5'(OSC_SETTLE_CYCLES - 1)) ? OSC_ON : OSC_START;
         OSC_ON:    osc_state_nxt = o_adc_osc_on ? OSC_ON : OSC_OFF;
         default:   osc_state_nxt = OSC_OFF;
      endcase
   end

   // State and settle counter.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_state_r <= OSC_OFF;
         osc_cnt_r   <= 5'h00;
      end else begin
         osc_state_r <= osc_state_nxt;
         osc_cnt_r   <= (osc_state_r == OSC_START) ? osc_cnt_r + 5'h01 : 5'h00;
      end
   end

   // ****************************************************************
   // Outputs to the clock tree.
   // ****************************************************************
   // port reset levels
   assign o_port_reset = {port_rst_r[POS_PORT_F_RESET], port_rst_r[POS_PORT_D_RESET],
                          port_rst_r[POS_PORT_C_RESET], port_rst_r[POS_PORT_B_RESET],
                          port_rst_r[POS_PORT_A_RESET]};
   assign o_pll_input_div       = pll_div_r[POS_PLL_DIV_LSB +: 4];
   // ADC source bit is passed through only.
   assign o_adc_clock_select    = clk_sel_r[POS_ADC_SEL];
   assign o_adc_osc_trim        = osc_trim_r;
   assign o_adc_osc_calibration = osc_cal_r;

   wire [1:0] uart_sel = clk_sel_r[POS_UART_SEL_LSB +: 2];
   wire       uart_lo;  // Choice between bus clock and system clock.
   wire       uart_hi;  // Choice between low-speed external and high-speed internal.

   // UART clock tree of glitch-free stages.
   ccprc_glitch_free_mux u_uart_lo (
      .i_resetn (i_resetn),
      .i_clk0   (i_pclk),
      .i_clk1   (i_system_clock),
      .i_sel    (uart_sel == UART_SRC_SYSTEM_CLOCK),
      .o_clk    (uart_lo)
   );
   ccprc_glitch_free_mux u_uart_hi (
      .i_resetn (i_resetn),
      .i_clk0   (i_low_speed_external_clock),
      .i_clk1   (i_high_speed_internal_clock),
      .i_sel    (uart_sel == UART_SRC_HSI),
      .o_clk    (uart_hi)
   );
   ccprc_glitch_free_mux u_uart_top (
      .i_resetn (i_resetn),
      .i_clk0   (uart_lo),
      .i_clk1   (uart_hi),
      .i_sel    (uart_sel[1]),
      .o_clk    (o_uart_kernel_clock)
   );

   ccprc_glitch_free_mux u_i2c (
      .i_resetn (i_resetn),
      .i_clk0   (i_high_speed_internal_clock),
      .i_clk1   (i_system_clock),
      .i_sel    (clk_sel_r[POS_I2C_SEL]),
      .o_clk    (o_i2c_kernel_clock)
   );

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   // helper run counter. Cycles the run command has stood high, held at its top value.
   logic [4:0] on_run_r;
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         on_run_r <= 5'h00;
      end else begin
         on_run_r <= !o_adc_osc_on ? 5'h00 : (&on_run_r) ? on_run_r : on_run_r + 5'h01;
      end
   end
   property p_port_write;
      (wr_prt && i_s_axi_wstrb[2]) |=> (o_port_reset[0] == $past(i_s_axi_wdata[POS_PORT_A_RESET]));
   endproperty
   a_port_write: assert property (p_port_write) else $error("Port A reset did not follow write.");
   property p_pll_div;
      (wr_pll && i_s_axi_wstrb[0]) |=> (o_pll_input_div == $past(i_s_axi_wdata[3:0]));
   endproperty
   a_pll_div: assert property (p_pll_div) else $error("PLL divider did not follow write.");
   property p_resv_zero;
      ((port_rst_r & ~MASK_GPIO_PORT_RESET) == 0) && ((clk_sel_r & ~MASK_PERIPH_SEL) == 0);
   endproperty
   a_resv_zero: assert property (p_resv_zero) else $error("Reserved bits are not zero.");
   property p_no_wait;
      (wr_go |=> bvalid_r) and (rd_go |=> rvalid_r);
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("Access answer was delayed.");
   property p_ready_rise;
      (on_run_r > 5'(OSC_SETTLE_CYCLES)) |-> osc_img[POS_OSC_READY];
   endproperty
   a_ready_rise: assert property (p_ready_rise) else $error("Ready did not rise after settling.");
   property p_ready_fall;
      !o_adc_osc_on |=> !osc_img[POS_OSC_READY];
   endproperty
   a_ready_fall: assert property (p_ready_fall) else $error("Ready stayed after stop.");
   property p_enable_on;
      (wr_osc && i_s_axi_wstrb[0] && i_s_axi_wdata[0]) |=> o_adc_osc_on;
   endproperty
   a_enable_on: assert property (p_enable_on) else $error("Enable write did not start oscillator.");
   property p_block;
      (osc_blk_r && !osc_en_r) |-> !o_adc_osc_on;
   endproperty
   a_block: assert property (p_block) else $error("Blocked request ran oscillator.");
   property p_trim;
      (wr_osc && i_s_axi_wstrb[0]) |=> (o_adc_osc_trim == $past(i_s_axi_wdata[7:3]));
   endproperty
   a_trim: assert property (p_trim) else $error("Trim did not follow write.");
   property p_cal;
      cal_loaded_r |-> (o_adc_osc_calibration == CAL_VALUE);
   endproperty
   a_cal: assert property (p_cal) else $error("Calibration not loaded.");

   c_port_write: cover property (wr_prt);
   c_ready:      cover property (osc_state_r == OSC_ON);
   c_unmapped:   cover property (wr_go && !wr_hit);

endmodule
